/* rtl/ptm_trim_margin_regs.sv */
// Purpose: command registers for revision, scratch, trim and margin high
// Assumes: requests are single-cycle pulses already decoded from the bus
// Notes:   all outputs registered; reference offset is in 1.953 mV counts
////////////////////////////////////////////////////////////////////////////
// How it works
// - revision command is read-only, returns one 16-bit word via block read
// - revision count is zero for first silicon, increments per revision
// - block read reports byte count two, low byte then high byte
// - scratch accepts writes in lower eight bits only
// - scratch served by word transactions only, never block read or write
// - store-all saves scratch and trim to nonvolatile storage
// - trim adds a constant signed offset to error amp reference
// - loop slave refuses trim/margin access: NACK, no write, fault, alert
// - trim spans -64 to +63 output counts
// - out-of-range write clamps, raises alert, comm fault, invalid data
// - combined reference bounded by max, min, command and other offsets
// - reference slew rate chosen by operating state
// - trim is sixteen-bit two's complement, high byte sign extension
// - trim resets to zero, no offset until written
// - margin high operation raises output by margin-high offset
// - margin-high offset ranges zero to thirty-one counts
// - only five low margin-high bits writable, rest read-only
// - margin high restores to 0009h or 000Fh by restore select
// - output format fixed linear with exponent minus nine
module ptm_trim_margin_regs
  import ptm_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire ptm_req_t           req,
  input  wire logic               loopSlave,
  input  wire logic               marginHighRestoreSelect,
  input  wire logic               restoreNow,
  input  wire logic               storeAll,
  input  wire logic               nvValid,
  input  wire logic [15:0]        nvScratch,
  input  wire logic [15:0]        nvTrim,
  input  wire logic               marginHighOp,
  input  wire ptm_opstate_t       opState,
  input  wire logic signed [15:0] voutCommand,
  input  wire logic signed [15:0] voutMax,
  input  wire logic signed [15:0] voutMin,
  input  wire logic               clearFaults,
  output ptm_rsp_t                rsp,
  output logic                    alert,
  output logic                    commFault,
  output logic                    invalidData,
  output logic                    invalid_command_fault,
  output logic                    nvWrite,
  output logic [15:0]             nvScratchOut,
  output logic [15:0]             nvTrimOut,
  output logic signed [15:0]      error_amp_reference,
  output ptm_slew_t               slewSelect,
  output logic [4:0]              voutExponent
);

  // clamp a signed value into [lo, hi]
  function automatic logic signed [15:0] clampS(
    input logic signed [15:0] v,
    input logic signed [15:0] lo,
    input logic signed [15:0] hi);
    clampS = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // true when v lies outside [lo, hi]
  function automatic logic outside(
    input logic signed [15:0] v,
    input logic signed [15:0] lo,
    input logic signed [15:0] hi);
    outside = (v < lo) || (v > hi);
  endfunction

  logic [7:0]         scratchLow;
  logic signed [15:0] trim;
  logic [4:0]         marginHigh;

  ////////////////////////////////////////////////////////////////////////
  // command decode
  wire logic access    = req.write | req.read;
  wire logic hitRev    = req.cmd == PTM_CMD_REV;
  wire logic hitScr    = req.cmd == PTM_CMD_SCRATCH;
  wire logic hitTrim   = req.cmd == PTM_CMD_TRIM;
  wire logic hitMhi    = req.cmd == PTM_CMD_MHI;
  wire logic hitLoop   = hitTrim | hitMhi;
  wire logic refused   = access & hitLoop & loopSlave;
  wire logic badRev    = req.write & hitRev;
  wire logic badScr    = access & hitScr & req.isBlock;
  wire logic known     = hitRev | hitScr | hitLoop;
  wire logic doNack    = access & (refused | badRev | badScr | ~known);
  wire logic wrScr     = req.write & hitScr & ~doNack;
  wire logic wrTrim    = req.write & hitTrim & ~doNack;
  wire logic wrMhi     = req.write & hitMhi & ~doNack;

  // range checks on written values
  wire logic signed [15:0] wrVal = req.data;
  wire logic trimBad = wrTrim & outside(wrVal, PTM_TRIM_MIN, PTM_TRIM_MAX);
  wire logic mhiBad  = wrMhi & outside(wrVal, PTM_MHI_MIN, PTM_MHI_MAX);
  wire logic rangeErr = trimBad | mhiBad;
  wire logic signed [15:0] trimClamped =
    clampS(wrVal, PTM_TRIM_MIN, PTM_TRIM_MAX);
  wire logic signed [15:0] mhiClamped  =
    clampS(wrVal, PTM_MHI_MIN, PTM_MHI_MAX);

  // read data: read-only bits come back as zero or sign
  wire logic [15:0] readVal =
    hitRev  ? PTM_SILICON_REV :
    hitScr  ? {8'h00, scratchLow} :
    hitTrim ? trim :
    hitMhi  ? {11'h000, marginHigh} : 16'h0000;
  wire logic [7:0] readCount = hitRev ? PTM_REV_COUNT : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // reference computation and slew selection
  wire logic signed [15:0] mhiOffset =
    marginHighOp ? $signed({11'h000, marginHigh}) : 16'sh0000;
  wire logic signed [15:0] refRaw = 16'(voutCommand + trim + mhiOffset);
  wire logic signed [15:0] refBound =
    clampS(refRaw, voutMin, voutMax);
  wire ptm_slew_t slewNext =
    (opState == PTM_ST_SOFTSTART) ? PTM_SLEW_RISE :
    (opState == PTM_ST_SOFTSTOP)  ? PTM_SLEW_FALL : PTM_SLEW_TRAN;
  wire logic [4:0] mhiRestore = marginHighRestoreSelect ?
    PTM_MHI_RST1[4:0] : PTM_MHI_RST0[4:0];

  ////////////////////////////////////////////////////////////////////////
  // register storage
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scratchLow <= PTM_SCRATCH_RST[7:0];
      trim       <= PTM_TRIM_RST;
      marginHigh <= mhiRestore;
    end else if (restoreNow) begin
      marginHigh <= mhiRestore;
      if (nvValid) begin
        scratchLow <= nvScratch[7:0];
        trim       <= clampS(nvTrim, PTM_TRIM_MIN, PTM_TRIM_MAX);
      end
    end else begin
      if (wrScr)
        scratchLow <= req.data[7:0] & PTM_SCRATCH_MSK;
      if (wrTrim)
        trim <= trimClamped;
      if (wrMhi)
        marginHigh <= mhiClamped[4:0];
    end
  end

  // response to each request, one cycle after it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rsp <= '0;
    end else begin
      rsp.ack       <= access & ~doNack;
      rsp.nack      <= doNack;
      rsp.byteCount <= (req.read & ~doNack) ? readCount : 8'h00;
      rsp.data      <= (req.read & ~doNack) ? readVal : 16'h0000;
    end
  end

  // fault flags: set wins over clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      commFault             <= 1'b0;
      invalidData           <= 1'b0;
      invalid_command_fault <= 1'b0;
      alert                 <= 1'b0;
    end else begin
      invalid_command_fault <= doNack | (invalid_command_fault & ~clearFaults);
      invalidData <= rangeErr | (invalidData & ~clearFaults);
      commFault   <= doNack | rangeErr | (commFault & ~clearFaults);
      alert       <= doNack | rangeErr | (alert & ~clearFaults);
    end
  end

  // nonvolatile save and analog-facing outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      nvWrite             <= 1'b0;
      nvScratchOut        <= 16'h0000;
      nvTrimOut           <= 16'h0000;
      error_amp_reference <= 16'sh0000;
      slewSelect          <= PTM_SLEW_RISE;
      voutExponent        <= PTM_VOUT_EXP;
    end else begin
      nvWrite             <= storeAll;
      nvScratchOut        <= {8'h00, scratchLow};
      nvTrimOut           <= trim;
      error_amp_reference <= refBound;
      slewSelect          <= slewNext;
      voutExponent        <= PTM_VOUT_EXP;
    end
  end

endmodule // ptm_trim_margin_regs

/* rtl/ptm_pkg.sv */
// Purpose: constants and carriers for the trim/margin command registers
// Assumes: one clock, synchronous active-low reset
// Notes:   command codes are the register offsets on the command port
package ptm_pkg;

  localparam logic [7:0]  PTM_CMD_REV     = 8'hAE;
  localparam logic [7:0]  PTM_CMD_SCRATCH = 8'hD0;
  localparam logic [7:0]  PTM_CMD_TRIM    = 8'hD4;
  localparam logic [7:0]  PTM_CMD_MHI     = 8'hD5;

  // revision count, arbitrary neutral value; first silicon counts from zero
  localparam logic [15:0] PTM_SILICON_REV = 16'h0000;
  localparam logic [7:0]  PTM_REV_COUNT   = 8'h02;

  localparam logic [15:0] PTM_SCRATCH_RST = 16'h0000;
  localparam logic [15:0] PTM_TRIM_RST    = 16'h0000;
  localparam logic [15:0] PTM_MHI_RST0    = 16'h0009;
  localparam logic [15:0] PTM_MHI_RST1    = 16'h000F;
  localparam logic [7:0]  PTM_SCRATCH_MSK = 8'hFF;

  localparam logic signed [15:0] PTM_TRIM_MIN = 16'shFFC0; // -64
  localparam logic signed [15:0] PTM_TRIM_MAX = 16'sh003F; // +63
  localparam logic signed [15:0] PTM_MHI_MIN  = 16'sh0000;
  localparam logic signed [15:0] PTM_MHI_MAX  = 16'sh001F; // 31

  localparam logic [4:0]  PTM_VOUT_EXP    = 5'h17;   // linear, exponent -9

  typedef enum logic [1:0] {
    PTM_SLEW_RISE = 2'h0,
    PTM_SLEW_TRAN = 2'h1,
    PTM_SLEW_FALL = 2'h3
  } ptm_slew_t;

  typedef enum logic [1:0] {
    PTM_ST_SOFTSTART = 2'h0,
    PTM_ST_STEADY    = 2'h1,
    PTM_ST_TOFFDLY   = 2'h3,
    PTM_ST_SOFTSTOP  = 2'h2
  } ptm_opstate_t;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [7:0]  cmd;
    logic        isBlock;
    logic [15:0] data;
  } ptm_req_t;

  typedef struct packed {
    logic        ack;
    logic        nack;
    logic [7:0]  byteCount;
    logic [15:0] data;
  } ptm_rsp_t;

endpackage

/* testbench/ptm_regs_asserts.sv */
// Purpose: port assertions for the trim and margin command registers
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every instance of the register block
module ptm_regs_asserts
  import ptm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire ptm_req_t    req,
  input  wire logic        loopSlave,
  input  wire logic        storeAll,
  input  wire ptm_rsp_t    rsp,
  input  wire logic        alert,
  input  wire logic        commFault,
  input  wire logic        invalidData,
  input  wire logic        invalid_command_fault,
  input  wire logic        nvWrite,
  input  wire logic [15:0] nvScratchOut,
  input  wire logic [15:0] nvTrimOut,
  input  wire logic [4:0]  voutExponent
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // request decode shared by the properties
  wire go  = req.read | req.write;
  wire trm = req.cmd == PTM_CMD_TRIM;
  sequence s_rev; req.read && req.cmd == PTM_CMD_REV; endsequence
  sequence s_pulse; nvWrite ##1 !nvWrite; endsequence
  a_slave_nack: assert property (
    go && trm && loopSlave |=> rsp.nack && invalid_command_fault && alert)
    else $error("loop slave access not refused");
  a_rev_count: assert property (s_rev |=> rsp.ack && rsp.byteCount == 8'h02)
    else $error("revision byte count wrong");
  a_rev_value: assert property (s_rev |=> rsp.data == PTM_SILICON_REV)
    else $error("revision word wrong");
  a_rev_refuse: assert property (
    req.write && req.cmd == PTM_CMD_REV |=> rsp.nack) else $error("rev write taken");
  a_store_pulse: assert property (storeAll |=> s_pulse)
    else $error("store pulse missing");
  a_scratch_top: assert property (nvScratchOut[15:8] == 8'h00)
    else $error("scratch upper byte set");
  a_exp_fixed: assert property (voutExponent == PTM_VOUT_EXP)
    else $error("exponent changed");
  a_trim_span: assert property ($signed(nvTrimOut) >= PTM_TRIM_MIN &&
    $signed(nvTrimOut) <= PTM_TRIM_MAX) else $error("trim out of span");
  a_clamp_flag: assert property (req.write && trm && !loopSlave &&
    $signed(req.data) > PTM_TRIM_MAX |=> invalidData && commFault && alert)
    else $error("clamp flags missing");
endmodule // ptm_regs_asserts
bind ptm_trim_margin_regs ptm_regs_asserts u_chk (.clk, .resetn, .req,
  .loopSlave, .storeAll, .rsp, .alert, .commFault, .invalidData,
  .invalid_command_fault, .nvWrite, .nvScratchOut, .nvTrimOut, .voutExponent);

/* testbench/ptm_host.sv */
// Purpose: host model issuing word and block commands
// Assumes: request taken one edge after raising, answer stands after it
// Notes:   data lines are inverted once the request is dropped
module ptm_host
  import ptm_pkg::*;
(
  input  wire logic     clk,
  input  wire ptm_rsp_t rsp,
  output ptm_req_t      req
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req = '0;
  // one transfer: raise, take the answer that the taking edge launched,
  // then drop; the answer stands only in the cycle after the taking edge
  task automatic xfer(input logic w, input logic [7:0] c,
    input logic [15:0] d, output ptm_rsp_t r);
    @(posedge clk) #2;
    req = '{w, !w, c, c == PTM_CMD_REV, d};
    @(posedge clk) #2;
    r = rsp;
    req.write = 1'b0;
    req.read = 1'b0;
    req.data = ~d;
  endtask
endmodule // ptm_host

/* testbench/tb_ptm_trim_margin_regs.sv */
// Purpose: self-checking bench for the trim and margin command registers
// Assumes: 40 MHz clock, inputs driven 2 ns after the rising edge
// Notes:   table rows write then read back; odd cases follow by hand
module tb_ptm_trim_margin_regs
  import ptm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] cmd; logic [15:0] wr; logic [15:0] rd; logic err;
  } ptm_row_t;
  logic clk = 0, resetn = 0, lsl = 0, sel = 0, rst = 0, sto = 0, mho = 0;
  logic clr = 0, alert, icf, inv, nvw;
  logic signed [15:0] vMax = 16'sh0140, eaRef;
  logic [15:0] nvTrim;
  ptm_req_t req;
  ptm_rsp_t rsp, r;
  int fail_count = 0, n_checks = 0;
  ptm_row_t rows[6] = '{'{PTM_CMD_SCRATCH, 16'hABCD, 16'h00CD, 1'b0},
    '{PTM_CMD_TRIM, 16'h0100, 16'h003F, 1'b1},
    '{PTM_CMD_TRIM, 16'h8000, 16'hFFC0, 1'b1},
    '{PTM_CMD_MHI, 16'h0040, 16'h001F, 1'b1},
    '{PTM_CMD_MHI, 16'h0014, 16'h0014, 1'b0},
    '{PTM_CMD_TRIM, 16'hFFF0, 16'hFFF0, 1'b0}};
  always #12.5 clk = ~clk;
  ptm_host host (.clk, .rsp, .req);
  ptm_trim_margin_regs dut (.clk, .resetn, .req, .loopSlave(lsl),
    .marginHighRestoreSelect(sel), .restoreNow(rst), .storeAll(sto),
    .nvValid(1'b0), .nvScratch(16'h0000), .nvTrim(16'h0000),
    .marginHighOp(mho), .opState(PTM_ST_STEADY), .voutCommand(16'sh0100),
    .voutMax(vMax), .voutMin(16'sh0000), .clearFaults(clr), .rsp,
    .alert, .commFault(), .invalidData(inv), .invalid_command_fault(icf),
    .nvWrite(nvw), .nvScratchOut(), .nvTrimOut(nvTrim),
    .error_amp_reference(eaRef), .slewSelect(), .voutExponent());
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog cuts a hang short
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    #2 resetn = 1;
    host.xfer(0, PTM_CMD_TRIM, 0, r); chk(r.data === 16'h0000, "trim reset");
    host.xfer(0, PTM_CMD_MHI, 0, r); chk(r.data === 16'h0009, "mhi reset");
    host.xfer(0, PTM_CMD_REV, 0, r);
    chk(r.ack === 1'b1 && r.byteCount === 8'h02, "rev count");
    host.xfer(1, PTM_CMD_REV, 16'h1234, r); chk(r.nack === 1'b1, "rev write");
    foreach (rows[i]) begin
      host.xfer(1, rows[i].cmd, rows[i].wr, r);
      chk(r.ack === 1'b1 && inv === rows[i].err, "write flags");
      host.xfer(0, rows[i].cmd, 0, r);
      chk(r.data === rows[i].rd, "readback");
      @(posedge clk) #2 clr = 1;
      @(posedge clk) #2 clr = 0;
    end
    mho = 1;
    repeat (3) @(posedge clk);
    chk(eaRef === 16'sh0104, "reference sum");
    #2 vMax = 16'sh0100;
    repeat (3) @(posedge clk);
    chk(eaRef === 16'sh0100, "reference bound");
    @(posedge clk) #2 sto = 1;
    @(posedge clk) #2 sto = 0;
    chk(nvw === 1'b1 && nvTrim === 16'hFFF0, "store");
    lsl = 1;
    host.xfer(1, PTM_CMD_TRIM, 16'h0005, r);
    chk(r.nack === 1'b1 && icf === 1'b1 && alert === 1'b1, "slave");
    lsl = 0;
    host.xfer(0, PTM_CMD_TRIM, 0, r); chk(r.data === 16'hFFF0, "dropped");
    sel = 1;
    @(posedge clk) #2 rst = 1;
    @(posedge clk) #2 rst = 0;
    host.xfer(0, PTM_CMD_MHI, 0, r); chk(r.data === 16'h000F, "restore");
    finish_test();
  end
endmodule // tb_ptm_trim_margin_regs
